/* File: hdl/dac_cal_pkg.sv */
// Shared constants and types of the calibration correction block.
// Assumes a single clock domain and an AXI4-Lite master with 32-bit data.
package dac_cal_pkg;

	// ------------------------------------------------------------
	// Geometry
	// ------------------------------------------------------------
	localparam int CH_COUNT   = 8;
	localparam int GROUP_SIZE = 4;
	localparam int GROUP_COUNT = 2;
	localparam int CODE_W     = 14;
	localparam int CH_W       = 3;
	localparam int ADDR_W     = 8;
	localparam int QUEUE_DEPTH = 8;

	// ------------------------------------------------------------
	// Arithmetic constants
	// ------------------------------------------------------------
	localparam logic [14:0] GAIN_BIAS = 15'h2000;
	localparam int          GAIN_SHIFT = 14;
	localparam logic [13:0] CODE_MAX  = 14'h3FFF;
	localparam logic [13:0] MSB_FLIP  = 14'h2000;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CFG_OFF      = 8'h00;
	localparam logic [7:0] STAT_OFF     = 8'h04;
	localparam logic [7:0] OFFSET_A_OFF = 8'h08;
	localparam logic [7:0] OFFSET_B_OFF = 8'h0C;
	localparam logic [7:0] INPUT_BASE   = 8'h20;
	localparam logic [7:0] DATA_BASE    = 8'h40;
	localparam logic [7:0] GAIN_BASE    = 8'h60;
	localparam logic [7:0] ZERO_BASE    = 8'h80;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int CFG_CE_BIT    = 0;
	localparam int CFG_GAIN4_BIT = 1;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_FMT_BIT  = 1;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [13:0] GAIN_RST  = 14'h2000;
	localparam logic [13:0] ZERO_RST  = 14'h0000;
	localparam logic [13:0] INPUT_RST = 14'h0000;
	localparam logic [13:0] DATA_RST  = 14'h0000;
	localparam logic [1:0]  CFG_RST   = 2'h0;
	localparam logic [13:0] OFFSET_G6_RST = 14'h2666;
	localparam logic [13:0] OFFSET_G4_RST = 14'h2AAB;

	// ------------------------------------------------------------
	// Bus answers and engine states
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_LOAD = 2'b01,
		ENG_WAIT = 2'b10
	} eng_state_t;

endpackage

/* File: hdl/corr_if.sv */
// Link between the engine sequencer and the shared arithmetic unit.
// Assumes both ends run on the same clock.
interface corr_if;
	logic        start;
	logic [13:0] in_code;
	logic [13:0] gain;
	logic [13:0] zero;
	logic [13:0] result;
	logic        done;

	modport engine (output start, output in_code, output gain, output zero, input result, input done);
	modport math   (input start, input in_code, input gain, input zero, output result, output done);
endinterface

/* File: hdl/corr_math.sv */
// Shared multiply-add unit with clamping; one result a cycle after start.
// Assumes inputs stable in the start cycle.
module corr_math
(
	input  wire logic sys_clk,
	input  wire logic srst,
	corr_if.math      cif
);
	logic [28:0]        prod;
	logic signed [16:0] sum;
	logic [13:0]        next_result;
	logic               next_done;

	// ------------------------------------------------------------
	// Corrected code, clamped to the unsigned range
	// ------------------------------------------------------------
	always_comb
	begin
		prod = 29'(cif.in_code) * 29'(15'({1'b0, cif.gain}) + dac_cal_pkg::GAIN_BIAS);
		sum  = $signed({2'b00, prod[28:dac_cal_pkg::GAIN_SHIFT]})
			+ $signed({{3{cif.zero[13]}}, cif.zero});
		if (sum < 0)
			next_result = 14'h0000;
		else if (sum > $signed({3'b000, dac_cal_pkg::CODE_MAX}))
			next_result = dac_cal_pkg::CODE_MAX;
		else
			next_result = sum[13:0];
		next_done = cif.start;
	end

	// Result registers
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			cif.result <= 14'h0000;
			cif.done   <= 1'b0;
		end
		else
		begin
			cif.result <= next_result;
			cif.done   <= next_done;
		end
	end
endmodule

/* File: hdl/chan_fifo.sv */
// Queue of channel numbers awaiting correction, oldest first.
// Assumes push is only asserted while push_ready is high.
module chan_fifo
#(
	parameter int WIDTH = 3,
	parameter int DEPTH = 8
)
(
	input  wire logic             sys_clk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] push_data,
	input  wire logic             push,
	output logic                  push_ready,
	output logic      [WIDTH-1:0] pop_data,
	output logic                  pop_valid,
	input  wire logic             pop
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW:0]      next_count;
	logic             do_push;
	logic             do_pop;

	// Pointer and fill level update
	always_comb
	begin
		do_push     = push && (count != (PW+1)'(DEPTH));
		do_pop      = pop && (count != '0);
		next_wr_ptr = do_push ? PW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
		next_rd_ptr = do_pop ? PW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
		next_count  = count + (PW+1)'(do_push) - (PW+1)'(do_pop);
	end

	assign push_ready = (count != (PW+1)'(DEPTH));
	assign pop_valid  = (count != '0);
	assign pop_data   = mem[rd_ptr];

	// Storage and pointers
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
		if (do_push)
			mem[wr_ptr] <= push_data;
	end
endmodule

/* File: hdl/dac_cal_engine.sv */
// Calibration correction block: registers, bus slave and shared engine.
// Assumes an AXI4-Lite master on sys_clk and a static data-format pin.

// Function
// - Channels 0-3 group A, 4-7 group B
// - Each channel latches a 14-bit code
// - Corrected = in*(gain+2^13)/2^14 + zero
// - Input, gain and zero writes while enabled recompute and load channel
// - Gain register spans 0.5 to 1.5
// - Zero register spans -8192 to +8191
// - One arithmetic unit shared by all channels
// - Enable bit: 0 off, 1 on
// - Disabled: direct load, no calculation started
// - Gain and zero read back as written
// - Code source depends on enable bit
// - Gain resets to 8192, zero to 0
// - Input registers reset to zero
// - Offset codes default per gain, per group
// - Gain-select bit picks six or four
// - Gain straight binary, zero twos complement
// - Format pin selects binary or twos complement
// - Gain change reloads offset defaults
module dac_cal_engine
#(
	parameter logic [13:0] OFFSET_A_G6 = dac_cal_pkg::OFFSET_G6_RST,
	parameter logic [13:0] OFFSET_A_G4 = dac_cal_pkg::OFFSET_G4_RST,
	parameter logic [13:0] OFFSET_B_G6 = dac_cal_pkg::OFFSET_G6_RST,
	parameter logic [13:0] OFFSET_B_G4 = dac_cal_pkg::OFFSET_G4_RST
)
(
	input  wire logic         sys_clk,
	input  wire logic         srst,
	input  wire logic         data_format_select,
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	output logic [111:0]      dac_latch_code,
	output logic [27:0]       group_offset_code,
	output logic              amp_gain_six,
	output logic              correction_busy
);
	localparam int N = dac_cal_pkg::CH_COUNT;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [13:0]  input_reg [N];
	logic [13:0]  data_reg  [N];
	logic [13:0]  gain_reg  [N];
	logic [13:0]  zero_reg  [N];
	logic [13:0]  offset_reg [dac_cal_pkg::GROUP_COUNT];
	logic [1:0]   cfg;
	logic [13:0]  next_input [N];
	logic [13:0]  next_data  [N];
	logic [13:0]  next_gain  [N];
	logic [13:0]  next_zero  [N];
	logic [13:0]  next_offset [dac_cal_pkg::GROUP_COUNT];
	logic [1:0]   next_cfg;

	logic         aw_held;
	logic         w_held;
	logic [7:0]   aw_addr;
	logic [31:0]  w_data;
	logic [3:0]   w_strb;
	logic         next_aw_held;
	logic         next_w_held;
	logic [7:0]   next_aw_addr;
	logic [31:0]  next_w_data;
	logic [3:0]   next_w_strb;
	logic         next_bvalid;
	logic [1:0]   next_bresp;
	logic         next_rvalid;
	logic [1:0]   next_rresp;
	logic [31:0]  next_rdata;

	dac_cal_pkg::eng_state_t eng_state;
	dac_cal_pkg::eng_state_t next_eng_state;
	logic [2:0]   eng_ch;
	logic [2:0]   next_eng_ch;
	logic         next_busy;

	logic         wr_fire;
	logic         wr_hit;
	logic [2:0]   wr_ch;
	logic [2:0]   rd_ch;
	logic [13:0]  wr_val;
	logic [13:0]  fmt_mask;
	logic         q_push;
	logic         q_ready;
	logic [2:0]   q_data;
	logic         q_valid;
	logic         q_pop;
	logic         ce;

	corr_if cif ();

	// Format pin flips the code MSB between twos complement and straight binary
	assign fmt_mask = data_format_select ? dac_cal_pkg::MSB_FLIP : 14'h0000;
	assign ce       = cfg[dac_cal_pkg::CFG_CE_BIT];
	assign wr_ch    = aw_addr[4:2];
	assign rd_ch    = s_axi_araddr[4:2];
	assign wr_val   = {w_strb[1] ? w_data[13:8] : 6'h00, w_strb[0] ? w_data[7:0] : 8'h00};

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	chan_fifo #(
		.WIDTH (dac_cal_pkg::CH_W),
		.DEPTH (dac_cal_pkg::QUEUE_DEPTH)
	) u_queue (
		.sys_clk    (sys_clk),
		.srst       (srst),
		.push_data  (wr_ch),
		.push       (q_push),
		.push_ready (q_ready),
		.pop_data   (q_data),
		.pop_valid  (q_valid),
		.pop        (q_pop)
	);

	corr_math u_math (
		.sys_clk (sys_clk),
		.srst    (srst),
		.cif     (cif.math)
	);

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	// Address and data captured in either order; write stalls while queue full
	always_comb
	begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid && !s_axi_bready;
		next_bresp   = s_axi_bresp;
		wr_fire      = aw_held && w_held && !s_axi_bvalid && q_ready;
		if (s_axi_awvalid && s_axi_awready)
		begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_fire)
		begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_hit ? dac_cal_pkg::RESP_OKAY : dac_cal_pkg::RESP_SLVERR;
		end
	end

	// Read answer one cycle after the address is taken
	always_comb
	begin
		next_rvalid = s_axi_rvalid && !s_axi_rready;
		next_rresp  = s_axi_rresp;
		next_rdata  = s_axi_rdata;
		if (s_axi_arvalid && s_axi_arready)
		begin
			next_rvalid = 1'b1;
			next_rresp  = dac_cal_pkg::RESP_OKAY;
			next_rdata  = 32'h00000000;
			case (s_axi_araddr[7:5])
				dac_cal_pkg::INPUT_BASE[7:5]: next_rdata = {18'h00000, input_reg[rd_ch]};
				dac_cal_pkg::DATA_BASE[7:5]:  next_rdata = {18'h00000, data_reg[rd_ch] ^ fmt_mask};
				dac_cal_pkg::GAIN_BASE[7:5]:  next_rdata = {18'h00000, gain_reg[rd_ch]};
				dac_cal_pkg::ZERO_BASE[7:5]:  next_rdata = {18'h00000, zero_reg[rd_ch]};
				3'h0:
				begin
					case (s_axi_araddr)
						dac_cal_pkg::CFG_OFF:      next_rdata = {30'h00000000, cfg};
						dac_cal_pkg::STAT_OFF:     next_rdata = {30'h00000000, data_format_select, correction_busy};
						dac_cal_pkg::OFFSET_A_OFF: next_rdata = {18'h00000, offset_reg[0] ^ fmt_mask};
						dac_cal_pkg::OFFSET_B_OFF: next_rdata = {18'h00000, offset_reg[1] ^ fmt_mask};
						default:                   next_rresp = dac_cal_pkg::RESP_SLVERR;
					endcase
				end
				default: next_rresp = dac_cal_pkg::RESP_SLVERR;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	// Bus writes, engine loads and offset reload on gain change
	always_comb
	begin
		next_input  = input_reg;
		next_data   = data_reg;
		next_gain   = gain_reg;
		next_zero   = zero_reg;
		next_offset = offset_reg;
		next_cfg    = cfg;
		wr_hit      = 1'b1;
		q_push      = 1'b0;
		if (eng_state == dac_cal_pkg::ENG_WAIT && cif.done)
			next_data[eng_ch] = cif.result;
		if (wr_fire)
		begin
			case (aw_addr[7:5])
				dac_cal_pkg::INPUT_BASE[7:5]:
				begin
					next_input[wr_ch] = wr_val;
					q_push            = ce;
				end
				dac_cal_pkg::DATA_BASE[7:5]:
					next_data[wr_ch] = wr_val ^ fmt_mask;
				dac_cal_pkg::GAIN_BASE[7:5]:
				begin
					next_gain[wr_ch] = wr_val;
					q_push           = ce;
				end
				dac_cal_pkg::ZERO_BASE[7:5]:
				begin
					next_zero[wr_ch] = wr_val;
					q_push           = ce;
				end
				3'h0:
				begin
					case (aw_addr)
						dac_cal_pkg::CFG_OFF:
						begin
							next_cfg = {w_strb[0] ? w_data[1:0] : cfg};
							if (next_cfg[dac_cal_pkg::CFG_GAIN4_BIT] != cfg[dac_cal_pkg::CFG_GAIN4_BIT])
							begin
								next_offset[0] = next_cfg[dac_cal_pkg::CFG_GAIN4_BIT] ? OFFSET_A_G4 : OFFSET_A_G6;
								next_offset[1] = next_cfg[dac_cal_pkg::CFG_GAIN4_BIT] ? OFFSET_B_G4 : OFFSET_B_G6;
							end
						end
						dac_cal_pkg::STAT_OFF:     wr_hit = 1'b1;
						dac_cal_pkg::OFFSET_A_OFF: next_offset[0] = wr_val ^ fmt_mask;
						dac_cal_pkg::OFFSET_B_OFF: next_offset[1] = wr_val ^ fmt_mask;
						default:                   wr_hit = 1'b0;
					endcase
				end
				default: wr_hit = 1'b0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Shared engine sequencer
	// ------------------------------------------------------------
	// Takes one queued channel at a time, oldest first
	always_comb
	begin
		next_eng_state = eng_state;
		next_eng_ch    = eng_ch;
		q_pop          = 1'b0;
		cif.start      = 1'b0;
		case (eng_state)
			dac_cal_pkg::ENG_IDLE:
			begin
				if (q_valid)
				begin
					q_pop          = 1'b1;
					next_eng_ch    = q_data;
					next_eng_state = dac_cal_pkg::ENG_LOAD;
				end
			end
			dac_cal_pkg::ENG_LOAD:
			begin
				cif.start      = 1'b1;
				next_eng_state = dac_cal_pkg::ENG_WAIT;
			end
			dac_cal_pkg::ENG_WAIT:
			begin
				if (cif.done)
					next_eng_state = dac_cal_pkg::ENG_IDLE;
			end
			default: next_eng_state = dac_cal_pkg::ENG_IDLE;
		endcase
		next_busy = (next_eng_state != dac_cal_pkg::ENG_IDLE) || q_valid || q_push;
	end

	// Engine operands of the selected channel; input code in straight binary
	assign cif.in_code = input_reg[eng_ch] ^ fmt_mask;
	assign cif.gain    = gain_reg[eng_ch];
	assign cif.zero    = zero_reg[eng_ch];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < N; i++)
			begin
				input_reg[i] <= dac_cal_pkg::INPUT_RST;
				data_reg[i]  <= dac_cal_pkg::DATA_RST;
				gain_reg[i]  <= dac_cal_pkg::GAIN_RST;
				zero_reg[i]  <= dac_cal_pkg::ZERO_RST;
			end
			offset_reg[0] <= OFFSET_A_G6;
			offset_reg[1] <= OFFSET_B_G6;
			cfg           <= dac_cal_pkg::CFG_RST;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= dac_cal_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rresp   <= dac_cal_pkg::RESP_OKAY;
			s_axi_rdata   <= 32'h00000000;
			eng_state     <= dac_cal_pkg::ENG_IDLE;
			eng_ch        <= 3'h0;
			correction_busy <= 1'b0;
		end
		else
		begin
			input_reg     <= next_input;
			data_reg      <= next_data;
			gain_reg      <= next_gain;
			zero_reg      <= next_zero;
			offset_reg    <= next_offset;
			cfg           <= next_cfg;
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= !next_aw_held;
			s_axi_wready  <= !next_w_held;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rresp   <= next_rresp;
			s_axi_rdata   <= next_rdata;
			eng_state     <= next_eng_state;
			eng_ch        <= next_eng_ch;
			correction_busy <= next_busy;
		end
	end

	// ------------------------------------------------------------
	// Output latches, one slice per channel
	// ------------------------------------------------------------
	for (genvar g = 0; g < N; g++)
	begin : g_latch
		// Groups: channels 0-3 use offset A, 4-7 offset B
		always_ff @(posedge sys_clk)
		begin
			if (srst)
				dac_latch_code[g*14 +: 14] <= dac_cal_pkg::DATA_RST;
			else
				dac_latch_code[g*14 +: 14] <= next_data[g];
		end
	end

	// Offset codes and amplifier gain select
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			group_offset_code <= {OFFSET_B_G6, OFFSET_A_G6};
			amp_gain_six      <= 1'b1;
		end
		else
		begin
			group_offset_code <= {next_offset[1], next_offset[0]};
			amp_gain_six      <= !next_cfg[dac_cal_pkg::CFG_GAIN4_BIT];
		end
	end
endmodule

/* File: testbench/dac_cal_engine_chk.sv */
// Checker of reset values, offset reloads and engine timing.
// Bound into dac_cal_engine; sees only its ports.
module dac_cal_chk
#(
	parameter logic [13:0] OFFSET_A_G6 = 14'h2666,
	parameter logic [13:0] OFFSET_A_G4 = 14'h2AAB,
	parameter logic [13:0] OFFSET_B_G6 = 14'h2666,
	parameter logic [13:0] OFFSET_B_G4 = 14'h2AAB
)
(
	input wire logic         sys_clk,
	input wire logic         srst,
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic         s_axi_rvalid,
	input wire logic         s_axi_rready,
	input wire logic         s_axi_bvalid,
	input wire logic [111:0] dac_latch_code,
	input wire logic [27:0]  group_offset_code,
	input wire logic         amp_gain_six,
	input wire logic         correction_busy
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	reset_values_a: assert property ($fell(srst) |-> dac_latch_code == '0 && amp_gain_six && !correction_busy
		&& group_offset_code == {OFFSET_B_G6, OFFSET_A_G6}) else $error("bad values after reset");
	offset_reload_a: assert property ($changed(amp_gain_six) |-> group_offset_code ==
		(amp_gain_six ? {OFFSET_B_G6, OFFSET_A_G6} : {OFFSET_B_G4, OFFSET_A_G4})) else $error("offset not reloaded");
	gain_cause_a: assert property ($changed(amp_gain_six) || !$stable(group_offset_code)
		|-> $rose(s_axi_bvalid)) else $error("gain or offset moved without write");
	latch_cause_a: assert property (!$stable(dac_latch_code) |-> $rose(s_axi_bvalid)
		|| $past(correction_busy)) else $error("latch moved without cause");
	busy_cause_a: assert property ($rose(correction_busy) |-> $rose(s_axi_bvalid)) else $error("busy without write");
	busy_ends_a: assert property ($rose(correction_busy) |-> ##[1:200] !correction_busy) else $error("engine stuck");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	read_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answered twice");
	cover property ($rose(correction_busy));
	cover property ($changed(amp_gain_six));
	cover property (!$stable(dac_latch_code) && !$rose(s_axi_bvalid));
endmodule

bind dac_cal_engine dac_cal_chk #(.OFFSET_A_G6(OFFSET_A_G6), .OFFSET_A_G4(OFFSET_A_G4), .OFFSET_B_G6(OFFSET_B_G6),
	.OFFSET_B_G4(OFFSET_B_G4)) u_dac_cal_chk (.sys_clk(sys_clk), .srst(srst), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_bvalid(s_axi_bvalid), .dac_latch_code(dac_latch_code), .group_offset_code(group_offset_code),
	.amp_gain_six(amp_gain_six), .correction_busy(correction_busy));

/* File: testbench/host_bus.sv */
// Host model: AXI4-Lite master, one write and one read at a time.
// Assumes the bench bounds every wait with its watchdog.
module host_bus
(
	input  wire logic        sys_clk,
	output logic [7:0]       awaddr,
	output logic             awvalid,
	output logic [31:0]      wdata,
	output logic [3:0]       wstrb,
	output logic             wvalid,
	output logic             bready,
	input  wire logic        awready,
	input  wire logic        wready,
	input  wire logic        bvalid,
	input  wire logic [1:0]  bresp,
	output logic [7:0]       araddr,
	output logic             arvalid,
	output logic             rready,
	input  wire logic        arready,
	input  wire logic        rvalid,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle bus; responses always accepted
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, araddr, arvalid} = '0;
		wstrb = 4'hF;
		{bready, rready} = 2'h3;
	end

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		{aw, w} = 2'h3;
		awaddr <= a;
		wdata <= d;
		{awvalid, wvalid} <= 2'h3;
		while (aw || w)
		begin
			@(posedge sys_clk);
			if (awready)
				aw = 1'b0;
			if (wready)
				w = 1'b0;
			awvalid <= aw;
			wvalid <= w;
		end
		awaddr <= ~a;
		wdata <= ~d;
		do
			@(posedge sys_clk);
		while (!bvalid);
		r = bresp;
	endtask

	// Read: address held until taken, data taken with rvalid
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do
			@(posedge sys_clk);
		while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		do
			@(posedge sys_clk);
		while (!rvalid);
		d = rdata;
		r = rresp;
	endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench of the calibration correction block.
// Trim values at defaults; data-format pin low, raised only for the last checks.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic          sys_clk = 1'b0;
	logic          srst = 1'b1;
	logic          fmt_sel = 1'b0;
	logic [7:0]    awaddr, araddr;
	logic [31:0]   wdata, rdata;
	logic [3:0]    wstrb;
	logic [1:0]    bresp, rresp;
	logic          awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [111:0]  dac_latch_code;
	logic [27:0]   group_offset_code;
	logic          amp_gain_six, correction_busy;
	int            num_errors = 0;
	int            cmp_count = 0;
	int            tin[4] = '{14'h2000, 14'h3FFF, 14'h3000, 14'h0010};
	int            tg[4] = '{14'h2000, 14'h3FFF, 14'h0000, 14'h2000};
	int            tz[4] = '{-16, 0, 0, -256};
	localparam logic [1:0] OK = dac_cal_pkg::RESP_OKAY;
	localparam logic [1:0] ERR = dac_cal_pkg::RESP_SLVERR;

	// ----------------------------------------
	// Harness
	// ----------------------------------------
	always #20 sys_clk = ~sys_clk;

	dac_cal_engine u_dac_cal_engine (.sys_clk(sys_clk), .srst(srst), .data_format_select(fmt_sel),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .dac_latch_code(dac_latch_code), .group_offset_code(group_offset_code),
		.amp_gain_six(amp_gain_six), .correction_busy(correction_busy));

	host_bus u_host_bus (.sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .bready(bready), .awready(awready), .wready(wready), .bvalid(bvalid), .bresp(bresp),
		.araddr(araddr), .arvalid(arvalid), .rready(rready), .arready(arready), .rvalid(rvalid),
		.rdata(rdata), .rresp(rresp));

	// Checks, bus helpers and expected corrected code
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_code(input int c, input logic [13:0] exp);
		chk_val({18'h0, dac_latch_code[c*14 +: 14]}, {18'h0, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		u_host_bus.wr(a, d, r);
		chk_val({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		u_host_bus.rd(a, d, r);
		chk_val(d, exp);
		chk_val({30'h0, r}, {30'h0, er});
	endtask

	task automatic wait_idle;
		while (correction_busy)
			@(posedge sys_clk);
		@(posedge sys_clk);
	endtask

	function automatic logic [7:0] adr(input logic [7:0] base, input int c);
		return base + 8'(4 * c);
	endfunction

	function automatic logic [31:0] corr(input int i, input int g, input int z);
		int v;
		v = ((i * (g + 32'h2000)) >>> 14) + z;
		return (v < 0) ? 32'h0 : (v > 32'h3FFF) ? 32'h3FFF : 32'(v);
	endfunction

	task automatic stop_test;
		if (num_errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		repeat (6) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		for (int c = 0; c < 8; c++)
		begin
			rd(adr(dac_cal_pkg::GAIN_BASE, c), 32'h2000, OK);
			rd(adr(dac_cal_pkg::ZERO_BASE, c), 32'h0, OK);
			rd(adr(dac_cal_pkg::INPUT_BASE, c), 32'h0, OK);
		end
		rd(dac_cal_pkg::OFFSET_B_OFF, 32'h2666, OK);
		rd(dac_cal_pkg::CFG_OFF, 32'h0, OK);
		wr(adr(dac_cal_pkg::INPUT_BASE, 2), 32'h1234, OK);
		chk_code(2, 14'h0000);
		wr(adr(dac_cal_pkg::DATA_BASE, 2), 32'h0ABC, OK);
		chk_code(2, 14'h0ABC);
		wr(adr(dac_cal_pkg::GAIN_BASE, 3), 32'h3000, OK);
		wr(adr(dac_cal_pkg::ZERO_BASE, 3), 32'h3FF0, OK);
		chk_val({31'h0, correction_busy}, 32'h0);
		rd(adr(dac_cal_pkg::GAIN_BASE, 3), 32'h3000, OK);
		rd(adr(dac_cal_pkg::ZERO_BASE, 3), 32'h3FF0, OK);
		wr(dac_cal_pkg::CFG_OFF, 32'h1, OK);
		for (int k = 0; k < 4; k++)
		begin
			wr(adr(dac_cal_pkg::GAIN_BASE, k + 4), 32'(tg[k]), OK);
			wr(adr(dac_cal_pkg::ZERO_BASE, k + 4), {18'h0, 14'(tz[k])}, OK);
			wr(adr(dac_cal_pkg::INPUT_BASE, k + 4), 32'(tin[k]), OK);
		end
		for (int c = 0; c < 4; c++)
			wr(adr(dac_cal_pkg::INPUT_BASE, c), 32'h0123 + 32'h1000 * c, OK);
		wait_idle;
		for (int k = 0; k < 4; k++)
		begin
			chk_code(k + 4, 14'(corr(tin[k], tg[k], tz[k])));
			rd(adr(dac_cal_pkg::DATA_BASE, k + 4), corr(tin[k], tg[k], tz[k]), OK);
			chk_code(k, 14'(corr(32'h0123 + 32'h1000 * k, k == 3 ? 32'h3000 : 32'h2000, k == 3 ? -16 : 0)));
		end
		wr(dac_cal_pkg::CFG_OFF, 32'h3, OK);
		chk_val({31'h0, amp_gain_six}, 32'h0);
		chk_val({4'h0, group_offset_code}, {4'h0, 14'h2AAB, 14'h2AAB});
		rd(dac_cal_pkg::OFFSET_A_OFF, 32'h2AAB, OK);
		rd(dac_cal_pkg::STAT_OFF, 32'h0, OK);
		// Twos complement coding on the format pin
		fmt_sel <= 1'b1;
		rd(dac_cal_pkg::STAT_OFF, 32'h2, OK);
		rd(dac_cal_pkg::OFFSET_A_OFF, 32'h0AAB, OK);
		wr(adr(dac_cal_pkg::DATA_BASE, 0), 32'h1FFF, OK);
		chk_code(0, 14'h3FFF);
		wr(adr(dac_cal_pkg::INPUT_BASE, 1), 32'h0, OK);
		wait_idle;
		chk_code(1, 14'h2000);
		wr(8'hF0, 32'h5, ERR);
		rd(8'hF0, 32'h0, ERR);
		stop_test;
	end

	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		stop_test;
	end
endmodule
